// ### hw/cap_pkg.sv
package cap_pkg;
  // Overview of operation
  // - in floppy powerdown, motor, drive select, write data and write gate float
  // - step direction, step, head, density and data rate stay driven in powerdown
  // - serial port direct powerdown follows serial power config bits 3 and 7
  // - serial auto powerdown allowed only by auto power config bits 5 and 6
  // - transmitter sleeps once holding buffer and shift register are both empty
  // - receiver sleeps once receive FIFO is empty and waiting for start bit, and stays asleep until a line change
  // - ring indicator change still raises its event while port sleeps
  // - host write to transmit holding buffer wakes the transmitter
  // - any level change on serial receive input wakes the receiver
  // - parallel port direct powerdown follows parallel power config bit 2
  // - parallel auto powerdown allowed only by auto power config bit 4
  // - extended mode logic sleeps when not configured or, with ecp configured, not chosen in ecr
  // - capabilities logic sleeps when not configured or ecr picks a simple mode
  // - parallel sleep state is re-evaluated whenever ecr or config mode changes
  // - primary disk select goes low for host access to base plus 0 to 7
  // - secondary disk select goes low for host access to its base plus 6
  // - task file data register is a 16-bit transfer, others are 8-bit
  // - strap sampled as reset falls: 0 puts port at 3F0H, 1 at 370H
  // - index and data ports ignored unless chip is in configuration state
  // - two successive 55H writes unlock; any other write between aborts entry
  // - index write picks register 0 to 2FH for data port accesses
  // - writing AAH to the configuration port leaves configuration mode
  localparam logic [9:0] CFG_PORT_LO  = 10'h3F0;
  localparam logic [9:0] CFG_PORT_HI  = 10'h370;
  localparam logic [9:0] DATA_OFS     = 10'h001;
  localparam logic [7:0] UNLOCK_KEY   = 8'h55;
  localparam logic [7:0] EXIT_KEY     = 8'hAA;
  localparam logic [7:0] IDX_LAST     = 8'h2F;
  localparam int         NUM_CR       = 48;
  localparam int         NUM_UART     = 2;
  localparam logic [5:0] CR_FDC       = 6'h00;
  localparam logic [5:0] CR_PP        = 6'h01;
  localparam logic [5:0] CR_UART      = 6'h02;
  localparam logic [5:0] CR_PPEXT     = 6'h04;
  localparam logic [5:0] CR_AUTO      = 6'h07;
  localparam logic [5:0] CR_PRI       = 6'h21;
  localparam logic [5:0] CR_SEC       = 6'h22;
  localparam int         FDC_PWR_BIT  = 3;
  localparam int         PP_PWR_BIT   = 2;
  localparam int         U1_PWR_BIT   = 3;
  localparam int         U2_PWR_BIT   = 7;
  localparam int         U1_AUTO_BIT  = 5;
  localparam int         U2_AUTO_BIT  = 6;
  localparam int         PP_AUTO_BIT  = 4;
  localparam int         EPP_CFG_BIT  = 0;
  localparam int         ECP_CFG_BIT  = 1;
  localparam logic [3:0] SEC_OFS      = 4'h6;
  localparam logic [2:0] WIDE_OFS     = 3'h0;
  localparam logic [2:0] ECR_SPP      = 3'h0;
  localparam logic [2:0] ECR_BIDIR    = 3'h1;
  localparam logic [2:0] ECR_EPP      = 3'h4;

  typedef enum logic [1:0] {ST_LOCKED, ST_ARMED, ST_CONFIG} cap_mode_t;

  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cap_bus_t;

  typedef struct packed {
    logic primary_disk_select_n;
    logic secondary_disk_select_n;
    logic wide16;
  } cap_disk_t;

  typedef struct packed {
    logic [3:0] motor_on_outputs;
    logic [3:0] drive_select_outputs;
    logic       write_data_output;
    logic       write_gate;
    logic       step_dir;
    logic       step;
    logic       head_select_output;
    logic       density_select_output;
    logic [1:0] data_rate_outputs;
  } cap_fdd_in_t;

  typedef struct packed {
    cap_fdd_in_t pins;
    logic        motor_on_oe;
    logic        drive_select_oe;
    logic        write_data_oe;
    logic        write_gate_oe;
  } cap_fdd_out_t;

  typedef struct packed {
    logic thr_empty;
    logic tsr_empty;
    logic rx_fifo_empty;
    logic rx_wait_start;
    logic transmit_holding_write;
    logic serial_receive_input;
    logic ring_indicator_input;
  } cap_uart_in_t;

  typedef struct packed {
    logic tx_pd;
    logic rx_pd;
    logic ri_event;
  } cap_uart_pm_t;

  typedef struct packed {
    logic         rxd_q;
    logic         ri_q;
    logic         tx_auto;
    logic         rx_auto;
    cap_uart_pm_t pm;
  } cap_uart_st_t;

  typedef struct packed {
    cap_mode_t                  mode;
    logic                       strap;
    logic [7:0]                 idx;
    logic [NUM_CR-1:0][7:0]     cr;
    logic [7:0]                 rdata;
    logic                       rvalid;
    cap_disk_t                  disk;
    cap_fdd_out_t               fdd;
    logic                       fdc_pd;
    logic                       pp_pd;
    logic                       epp_pd;
    logic                       ecp_pd;
  } cap_state_t;

  function automatic logic [7:0] cap_cr_reset(input logic [5:0] idx);
    case (idx)
      6'h00:   return 8'h28;
      6'h01:   return 8'h9C;
      6'h02:   return 8'h88;
      6'h03:   return 8'h78;
      6'h06:   return 8'hFF;
      6'h0C:   return 8'h02;
      6'h1E:   return 8'h3C;
      6'h20:   return 8'h3C;
      6'h21:   return 8'h3C;
      6'h22:   return 8'h3D;
      default: return 8'h00;
    endcase
  endfunction : cap_cr_reset
endpackage : cap_pkg

// ### hw/cap_uart_pm.sv
`timescale 1ns/100ps
module cap_uart_pm
  import cap_pkg::*;
(
  input  logic         clock_i,
  input  logic         reset_i,
  input  logic         direct_pd_i,
  input  logic         auto_en_i,
  input  cap_uart_in_t uart_i,
  output cap_uart_pm_t pm_o
);
  cap_uart_st_t st_r;
  cap_uart_st_t st_nxt;
  logic         rx_chg;

  assign pm_o = st_r.pm;

  always_comb
  begin
    st_nxt = st_r;
    rx_chg = uart_i.serial_receive_input != st_r.rxd_q;
    st_nxt.rxd_q = uart_i.serial_receive_input;
    st_nxt.ri_q = uart_i.ring_indicator_input;
    // wake beats entry in the same cycle
    st_nxt.tx_auto = auto_en_i && !uart_i.transmit_holding_write
      && (st_r.tx_auto || (uart_i.thr_empty && uart_i.tsr_empty));
    st_nxt.rx_auto = auto_en_i && !rx_chg
      && (st_r.rx_auto || (uart_i.rx_fifo_empty && uart_i.rx_wait_start));
    st_nxt.pm.tx_pd = direct_pd_i || st_nxt.tx_auto;
    st_nxt.pm.rx_pd = direct_pd_i || st_nxt.rx_auto;
    // ring event ignores sleep state on purpose
    st_nxt.pm.ri_event = uart_i.ring_indicator_input != st_r.ri_q;
    if (reset_i)
    begin
      st_nxt = '0;
      // track line at reset so release causes no false wake
      st_nxt.rxd_q = uart_i.serial_receive_input;
      st_nxt.ri_q = uart_i.ring_indicator_input;
    end
  end

  always_ff @(posedge clock_i)
  begin
    st_r <= st_nxt;
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  a_tx_enter_pd: assert property (
    auto_en_i && uart_i.thr_empty && uart_i.tsr_empty
    && !uart_i.transmit_holding_write |=> pm_o.tx_pd)
    else $error("transmitter did not enter powerdown");
  a_rx_enter_pd: assert property (
    auto_en_i && uart_i.rx_fifo_empty && uart_i.rx_wait_start
    && !$changed(uart_i.serial_receive_input) |=> pm_o.rx_pd)
    else $error("receiver did not enter powerdown");
  a_ring_follows: assert property (
    $changed(uart_i.ring_indicator_input) |=> pm_o.ri_event)
    else $error("ring change lost");
  a_tx_wake_write: assert property (
    uart_i.transmit_holding_write && !direct_pd_i |=> !pm_o.tx_pd)
    else $error("transmitter did not wake on write");
  a_rx_wake_edge: assert property (
    $changed(uart_i.serial_receive_input) && !direct_pd_i |=> !pm_o.rx_pd)
    else $error("receiver did not wake on line change");
endmodule : cap_uart_pm

// ### hw/cap_top.sv
`timescale 1ns/100ps
module cap_top
  import cap_pkg::*;
(
  input  logic                        clock_i,
  input  logic                        reset_i,
  input  logic                        port_base_strap_i,
  input  cap_bus_t                    bus_i,
  output logic [7:0]                  rdata_o,
  output logic                        rvalid_o,
  output cap_disk_t                   disk_o,
  input  cap_fdd_in_t                 fdd_i,
  input  logic                        fdc_auto_pd_i,
  output cap_fdd_out_t                fdd_o,
  output logic                        fdc_pd_o,
  input  cap_uart_in_t [NUM_UART-1:0] uart_i,
  output cap_uart_pm_t [NUM_UART-1:0] uart_o,
  input  logic [2:0]                  ecr_mode_i,
  output logic                        pp_pd_o,
  output logic                        epp_pd_o,
  output logic                        ecp_pd_o
);
  cap_state_t st_r;
  cap_state_t st_nxt;
  logic [9:0] cfg_base;
  logic [9:0] data_addr;
  logic       wr_cfg;
  logic       wr_data;
  logic       rd_data;
  logic       key_ok;
  logic       exit_ok;
  logic       idx_ok;
  logic [7:0] cur_cr;
  logic       acc;
  logic       pri_hit;
  logic       sec_hit;
  logic       fdd_pd;
  logic       epp_cfg;
  logic       ecp_cfg;
  logic       pp_auto;
  logic       ecr_simple;

  assign rdata_o  = st_r.rdata;
  assign rvalid_o = st_r.rvalid;
  assign disk_o   = st_r.disk;
  assign fdd_o    = st_r.fdd;
  assign fdc_pd_o = st_r.fdc_pd;
  assign pp_pd_o  = st_r.pp_pd;
  assign epp_pd_o = st_r.epp_pd;
  assign ecp_pd_o = st_r.ecp_pd;

  // port base chosen by the strap caught at reset release
  assign cfg_base  = st_r.strap ? CFG_PORT_HI : CFG_PORT_LO;
  assign data_addr = cfg_base + DATA_OFS;
  assign wr_cfg    = bus_i.wr && (bus_i.addr == cfg_base);
  assign wr_data   = bus_i.wr && (bus_i.addr == data_addr);
  assign rd_data   = bus_i.rd && (bus_i.addr == data_addr);
  assign key_ok    = bus_i.wdata == UNLOCK_KEY;
  assign exit_ok   = bus_i.wdata == EXIT_KEY;
  assign idx_ok    = st_r.idx <= IDX_LAST;
  // out-of-range index reads zero rather than a stray bank slot
  assign cur_cr    = idx_ok ? st_r.cr[st_r.idx[5:0]] : 8'h00;

  // task file decode uses the live strobe, so selects trail by one cycle
  assign acc     = bus_i.rd || bus_i.wr;
  assign pri_hit = (bus_i.addr[9:4] == st_r.cr[CR_PRI][7:2])
                   && !bus_i.addr[3];
  assign sec_hit = (bus_i.addr[9:4] == st_r.cr[CR_SEC][7:2])
                   && (bus_i.addr[3:0] == SEC_OFS);

  assign fdd_pd = !st_r.cr[CR_FDC][FDC_PWR_BIT] || fdc_auto_pd_i;

  assign epp_cfg    = st_r.cr[CR_PPEXT][EPP_CFG_BIT];
  assign ecp_cfg    = st_r.cr[CR_PPEXT][ECP_CFG_BIT];
  assign pp_auto    = st_r.cr[CR_AUTO][PP_AUTO_BIT];
  assign ecr_simple = (ecr_mode_i == ECR_SPP) || (ecr_mode_i == ECR_BIDIR)
                      || (ecr_mode_i == ECR_EPP);

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    case (st_r.mode)
      ST_LOCKED:
      begin
        if (wr_cfg && key_ok)
        begin
          st_nxt.mode = ST_ARMED;
        end
      end
      ST_ARMED:
      begin
        // any other write in between drops the unlock attempt
        if (bus_i.wr)
        begin
          st_nxt.mode = (wr_cfg && key_ok) ? ST_CONFIG : ST_LOCKED;
        end
      end
      ST_CONFIG:
      begin
        if (wr_cfg)
        begin
          if (exit_ok)
          begin
            st_nxt.mode = ST_LOCKED;
          end
          else
          begin
            st_nxt.idx = bus_i.wdata;
          end
        end
        else if (wr_data && idx_ok)
        begin
          st_nxt.cr[st_r.idx[5:0]] = bus_i.wdata;
        end
        if (rd_data)
        begin
          st_nxt.rdata  = cur_cr;
          st_nxt.rvalid = 1'b1;
        end
      end
      default:
      begin
        st_nxt.mode = ST_LOCKED;
      end
    endcase
    // outside ST_CONFIG the index and data ports fall through untouched

    st_nxt.disk.primary_disk_select_n   = !(acc && pri_hit);
    st_nxt.disk.secondary_disk_select_n = !(acc && sec_hit);
    st_nxt.disk.wide16 = acc && pri_hit
                         && (bus_i.addr[2:0] == WIDE_OFS);

    st_nxt.fdc_pd = fdd_pd;
    st_nxt.fdd.pins = fdd_i;
    // drive-facing outputs float so a powered-off drive draws no current
    st_nxt.fdd.motor_on_oe     = !fdd_pd;
    st_nxt.fdd.drive_select_oe = !fdd_pd;
    st_nxt.fdd.write_data_oe   = !fdd_pd;
    st_nxt.fdd.write_gate_oe   = !fdd_pd;

    // recomputed every cycle, so ecr or config changes act on the next clock
    st_nxt.pp_pd  = !st_r.cr[CR_PP][PP_PWR_BIT];
    st_nxt.epp_pd = pp_auto
                    && (!epp_cfg || (ecp_cfg && (ecr_mode_i != ECR_EPP)));
    st_nxt.ecp_pd = pp_auto
                    && (!ecp_cfg || ecr_simple);

    if (reset_i)
    begin
      st_nxt = '0;
      st_nxt.mode = ST_LOCKED;
      st_nxt.disk.primary_disk_select_n   = 1'b1;
      st_nxt.disk.secondary_disk_select_n = 1'b1;
      // last value seen while reset is high is the falling-edge sample
      st_nxt.strap = port_base_strap_i;
      for (int i = 0; i < NUM_CR; i++)
      begin
        st_nxt.cr[i] = cap_cr_reset(i[5:0]);
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    st_r <= st_nxt;
  end

  for (genvar g = 0; g < NUM_UART; g++)
  begin : g_uart
    localparam int PWR = (g == 0) ? U1_PWR_BIT : U2_PWR_BIT;
    localparam int AUT = (g == 0) ? U1_AUTO_BIT : U2_AUTO_BIT;
    // power bit set means running, clear forces sleep
    cap_uart_pm u_pm (
      .clock_i     (clock_i),
      .reset_i     (reset_i),
      .direct_pd_i (!st_r.cr[CR_UART][PWR]),
      .auto_en_i   (st_r.cr[CR_AUTO][AUT]),
      .uart_i      (uart_i[g]),
      .pm_o        (uart_o[g])
    );
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  a_fdd_outputs_float: assert property (
    fdd_pd |=> !fdd_o.motor_on_oe && !fdd_o.drive_select_oe
               && !fdd_o.write_data_oe && !fdd_o.write_gate_oe)
    else $error("drive outputs still enabled in powerdown");

  a_fdd_local_active: assert property (
    fdd_pd |=> (fdd_o.pins.step == $past(fdd_i.step))
               && (fdd_o.pins.step_dir == $past(fdd_i.step_dir))
               && (fdd_o.pins.data_rate_outputs == $past(fdd_i.data_rate_outputs)))
    else $error("local control outputs stopped in powerdown");

  a_uart_direct_pd: assert property (
    !st_r.cr[CR_UART][U2_PWR_BIT] |=> uart_o[1].tx_pd && uart_o[1].rx_pd)
    else $error("serial port not powered down directly");

  a_uart_auto_gate: assert property (
    !st_r.cr[CR_AUTO][U1_AUTO_BIT] && st_r.cr[CR_UART][U1_PWR_BIT]
    |=> !uart_o[0].tx_pd && !uart_o[0].rx_pd)
    else $error("serial auto powerdown without enable");

  a_pp_direct_pd: assert property (
    ##1 pp_pd_o == !$past(st_r.cr[CR_PP][PP_PWR_BIT]))
    else $error("parallel direct powerdown wrong");

  a_pp_auto_gate: assert property (
    !pp_auto |=> !epp_pd_o && !ecp_pd_o)
    else $error("parallel auto powerdown without enable");

  a_epp_sleeps: assert property (
    pp_auto && epp_cfg && ecp_cfg && (ecr_mode_i != ECR_EPP) |=> epp_pd_o)
    else $error("extended logic awake while unused");

  a_ecp_mode_track: assert property (
    pp_auto && ecp_cfg && $changed(ecr_mode_i)
    |=> ecp_pd_o == $past(ecr_simple))
    else $error("capabilities logic missed ecr change");

  a_disk_pri_sel: assert property (
    acc && pri_hit |=> !disk_o.primary_disk_select_n ##1 $past(acc)
                       || disk_o.primary_disk_select_n)
    else $error("primary disk select not asserted");

  a_disk_sec_sel: assert property (
    acc && !sec_hit |=> disk_o.secondary_disk_select_n)
    else $error("secondary disk select asserted off target");

  a_disk_wide: assert property (
    disk_o.wide16 |-> !disk_o.primary_disk_select_n)
    else $error("wide transfer outside primary select");

  a_strap_base: assert property (
    $fell(reset_i) |-> st_r.strap == $past(port_base_strap_i))
    else $error("strap not caught at reset release");

  a_locked_ignore: assert property (
    st_r.mode != ST_CONFIG |=> !rvalid_o && $stable(st_r.idx))
    else $error("index or data port acted while locked");

  a_unlock_abort: assert property (
    st_r.mode == ST_ARMED && bus_i.wr && !(wr_cfg && key_ok)
    |=> st_r.mode == ST_LOCKED)
    else $error("unlock survived an intervening write");

  a_index_route: assert property (
    st_r.mode == ST_CONFIG && rd_data |=> rvalid_o && rdata_o == $past(cur_cr))
    else $error("data port read not routed by index");

  a_exit_key: assert property (
    st_r.mode == ST_CONFIG && wr_cfg && exit_ok |=> st_r.mode == ST_LOCKED)
    else $error("exit key did not lock");

  a_fdd_drive_awake: assert property (
    !fdd_pd |=> fdd_o.motor_on_oe && fdd_o.drive_select_oe
                && fdd_o.write_data_oe && fdd_o.write_gate_oe)
    else $error("drive outputs floated while awake");

  a_fdd_pd_flag: assert property (
    ##1 fdc_pd_o == $past(fdd_pd))
    else $error("floppy powerdown flag wrong");

  a_fdd_head_active: assert property (
    fdd_pd |=> (fdd_o.pins.head_select_output == $past(fdd_i.head_select_output))
    && (fdd_o.pins.density_select_output == $past(fdd_i.density_select_output)))
    else $error("head or density output stopped in powerdown");

  a_uart0_direct_pd: assert property (
    !st_r.cr[CR_UART][U1_PWR_BIT] |=> uart_o[0].tx_pd && uart_o[0].rx_pd)
    else $error("first serial port not powered down directly");

  a_uart1_auto_gate: assert property (
    !st_r.cr[CR_AUTO][U2_AUTO_BIT] && st_r.cr[CR_UART][U2_PWR_BIT]
    |=> !uart_o[1].tx_pd && !uart_o[1].rx_pd)
    else $error("second serial port auto powerdown without enable");

  a_epp_unconfig: assert property (
    pp_auto && !epp_cfg |=> epp_pd_o)
    else $error("extended logic awake while unconfigured");

  a_epp_in_use: assert property (
    pp_auto && epp_cfg && (!ecp_cfg || (ecr_mode_i == ECR_EPP)) |=> !epp_pd_o)
    else $error("extended logic asleep while in use");

  a_ecp_unconfig: assert property (
    pp_auto && !ecp_cfg |=> ecp_pd_o)
    else $error("capabilities logic awake while unconfigured");

  a_ecp_in_use: assert property (
    pp_auto && ecp_cfg && !ecr_simple |=> !ecp_pd_o)
    else $error("capabilities logic asleep while in use");

  a_epp_mode_track: assert property (
    pp_auto && epp_cfg && ecp_cfg && $changed(ecr_mode_i)
    |=> epp_pd_o == ($past(ecr_mode_i) != ECR_EPP))
    else $error("extended logic missed ecr change");

  a_disk_pri_idle: assert property (
    !(acc && pri_hit) |=> disk_o.primary_disk_select_n)
    else $error("primary disk select asserted off target");

  a_disk_sec_hit: assert property (
    acc && sec_hit |=> !disk_o.secondary_disk_select_n)
    else $error("secondary disk select not asserted");

  a_disk_wide_data: assert property (
    acc && pri_hit && (bus_i.addr[2:0] == WIDE_OFS) |=> disk_o.wide16)
    else $error("data register not flagged wide");

  a_strap_hold: assert property (
    ##1 $stable(st_r.strap))
    else $error("port base changed outside reset");

  a_unlock_enter: assert property (
    st_r.mode == ST_ARMED && wr_cfg && key_ok |=> st_r.mode == ST_CONFIG)
    else $error("second key did not enter configuration");

  a_index_load: assert property (
    st_r.mode == ST_CONFIG && wr_cfg && !exit_ok |=> st_r.idx == $past(bus_i.wdata))
    else $error("index write not stored");

  a_data_write: assert property (
    st_r.mode == ST_CONFIG && wr_data && idx_ok |=> cur_cr == $past(bus_i.wdata))
    else $error("data port write not routed by index");

  a_locked_bank: assert property (
    st_r.mode != ST_CONFIG |=> $stable(st_r.cr))
    else $error("register bank changed outside configuration");

  c_unlock: cover property (
    st_r.mode == ST_LOCKED ##1 st_r.mode == ST_ARMED ##1 st_r.mode == ST_CONFIG);
  c_cfg_read: cover property (st_r.mode == ST_CONFIG && rd_data && idx_ok);
  c_fdd_sleep: cover property (fdd_pd ##1 !fdd_o.motor_on_oe);
  c_epp_sleep: cover property (epp_pd_o && !ecp_pd_o);
endmodule : cap_top

// ### verification/cap_host_model.sv
`timescale 1ns/100ps
module cap_host_model
  import cap_pkg::*;
(
  input  logic     clock_i,
  output cap_bus_t bus_o
);
  initial bus_o = '0;

  // one strobe cycle per access; released address and data show the inverse, both strobes drop low
  task automatic access(input logic [9:0] a, input logic [7:0] d, input logic w);
    @(posedge clock_i);
    bus_o <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clock_i);
    bus_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    #1;
  endtask : access

  // both keys back to back, nothing may slip in between
  task automatic unlock(input logic [9:0] p);
    access(p, UNLOCK_KEY, 1'b1);
    access(p, UNLOCK_KEY, 1'b1);
  endtask : unlock

  // index within 0 to 2FH, then data at index port plus one
  task automatic cfg_write(input logic [9:0] p, input logic [5:0] i, input logic [7:0] v);
    access(p, {2'h0, i}, 1'b1);
    access(p + DATA_OFS, v, 1'b1);
  endtask : cfg_write

  task automatic leave(input logic [9:0] p);
    access(p, EXIT_KEY, 1'b1);
  endtask : leave
endmodule : cap_host_model

// ### verification/test_config_access_and_power_gating.sv
`timescale 1ns/100ps
module test_config_access_and_power_gating;
  import cap_pkg::*;
  logic                        clock_i = 1'b0;
  logic                        reset_i = 1'b1;
  logic                        strap   = 1'b0;
  cap_bus_t                    bus;
  logic [7:0]                  rdata;
  logic                        rvalid;
  cap_disk_t                   disk;
  cap_fdd_in_t                 fdd     = '0;
  logic                        fdc_auto = 1'b0;
  cap_fdd_out_t                fdd_o;
  logic                        fdc_pd;
  cap_uart_in_t [NUM_UART-1:0] uart    = '0;
  cap_uart_pm_t [NUM_UART-1:0] upm;
  logic [2:0]                  ecr     = 3'h0;
  logic                        pp_pd;
  logic                        epp_pd;
  logic                        ecp_pd;
  logic [9:0]                  port;
  logic [9:0]                  dsk_a [5] = '{10'h0F0, 10'h0F7, 10'h0F6, 10'h0F8, 10'h0EF};
  logic [2:0]                  dsk_e [5] = '{3'b011, 3'b010, 3'b000, 3'b110, 3'b110};
  int                          n_fail = 0;
  int                          checks_done = 0;

  always #2 clock_i = ~clock_i;

  cap_host_model u_host (.clock_i(clock_i), .bus_o(bus));

  cap_top u_dut (
    .clock_i           (clock_i),
    .reset_i           (reset_i),
    .port_base_strap_i (strap),
    .bus_i             (bus),
    .rdata_o           (rdata),
    .rvalid_o          (rvalid),
    .disk_o            (disk),
    .fdd_i             (fdd),
    .fdc_auto_pd_i     (fdc_auto),
    .fdd_o             (fdd_o),
    .fdc_pd_o          (fdc_pd),
    .uart_i            (uart),
    .uart_o            (upm),
    .ecr_mode_i        (ecr),
    .pp_pd_o           (pp_pd),
    .epp_pd_o          (epp_pd),
    .ecp_pd_o          (ecp_pd)
  );

  task automatic chk_bit(input string name, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_byte

  task automatic wrap_up;
    if (n_fail == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick

  // strap held through the last reset edge, so the latched level is the one given
  task automatic do_reset(input logic s);
    @(posedge clock_i);
    reset_i <= 1'b1;
    strap   <= s;
    repeat (12) @(posedge clock_i);
    reset_i <= 1'b0;
    port = s ? CFG_PORT_HI : CFG_PORT_LO;
  endtask : do_reset

  task automatic cfg_rd(input logic [5:0] i, input logic [7:0] exp);
    u_host.access(port, {2'h0, i}, 1'b1);
    u_host.access(port + DATA_OFS, 8'h00, 1'b0);
    chk_bit("rvalid", 1'b1, rvalid);
    chk_byte("rdata", exp, rdata);
  endtask : cfg_rd

  initial
  begin
    repeat (20000) @(posedge clock_i);
    n_fail++;
    wrap_up();
  end

  initial
  begin
    do_reset(1'b0);
    u_host.unlock(port);
    cfg_rd(CR_FDC, 8'h28);
    u_host.cfg_write(port, CR_AUTO, 8'h30);
    cfg_rd(CR_AUTO, 8'h30);
    u_host.access(port, 8'h30, 1'b1);
    u_host.access(port + DATA_OFS, 8'h00, 1'b0);
    chk_byte("rdata beyond last", 8'h00, rdata);
    // parallel auto powerdown over mode codes 0 to 4
    u_host.cfg_write(port, CR_PPEXT, 8'h03);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clock_i);
      ecr <= i[2:0];
      tick(1);
      chk_bit("epp_pd", i != 4, epp_pd);
      chk_bit("ecp_pd", i != 2 && i != 3, ecp_pd);
    end
    u_host.cfg_write(port, CR_PPEXT, 8'h00);
    tick(1);
    chk_bit("epp_pd unconfigured", 1'b1, epp_pd);
    chk_bit("ecp_pd unconfigured", 1'b1, ecp_pd);
    u_host.cfg_write(port, CR_PP, 8'h98);
    tick(1);
    chk_bit("pp_pd", 1'b1, pp_pd);
    u_host.cfg_write(port, CR_AUTO, 8'h20);
    tick(1);
    chk_bit("epp_pd auto off", 1'b0, epp_pd);
    chk_bit("ecp_pd auto off", 1'b0, ecp_pd);
    // floppy pins, auto then direct powerdown
    @(posedge clock_i);
    fdd      <= 16'hA5C3;
    fdc_auto <= 1'b1;
    tick(1);
    chk_byte("fdd oe", 8'h00, {4'h0, fdd_o.motor_on_oe, fdd_o.drive_select_oe,
             fdd_o.write_data_oe, fdd_o.write_gate_oe});
    chk_bit("fdc_pd", 1'b1, fdc_pd);
    chk_byte("fdd active pins", {2'h0, fdd[5:0]}, {2'h0, fdd_o.pins[5:0]});
    @(posedge clock_i);
    fdc_auto <= 1'b0;
    fdd      <= 16'h5A3C;
    u_host.cfg_write(port, CR_FDC, 8'h20);
    tick(1);
    chk_bit("fdc_pd direct", 1'b1, fdc_pd);
    chk_bit("write gate oe", 1'b0, fdd_o.write_gate_oe);
    chk_byte("fdd active pins", {2'h0, fdd[5:0]}, {2'h0, fdd_o.pins[5:0]});
    // serial auto powerdown, port 0 enabled only
    @(posedge clock_i);
    uart <= {2{7'h78}};
    tick(1);
    chk_bit("tx_pd 0", 1'b1, upm[0].tx_pd);
    chk_bit("rx_pd 0", 1'b1, upm[0].rx_pd);
    chk_bit("tx_pd 1", 1'b0, upm[1].tx_pd);
    chk_bit("rx_pd 1", 1'b0, upm[1].rx_pd);
    @(posedge clock_i);
    uart[0].ring_indicator_input <= 1'b1;
    tick(1);
    chk_bit("ri_event asleep", 1'b1, upm[0].ri_event);
    tick(1);
    chk_bit("ri_event pulse", 1'b0, upm[0].ri_event);
    @(posedge clock_i);
    uart[0].transmit_holding_write <= 1'b1;
    uart[0].thr_empty              <= 1'b0;
    @(posedge clock_i);
    uart[0].transmit_holding_write <= 1'b0;
    #1;
    chk_bit("tx_pd wake", 1'b0, upm[0].tx_pd);
    chk_bit("rx_pd stays", 1'b1, upm[0].rx_pd);
    @(posedge clock_i);
    uart[0].serial_receive_input <= 1'b1;
    uart[0].rx_wait_start        <= 1'b0;
    tick(1);
    chk_bit("rx_pd wake", 1'b0, upm[0].rx_pd);
    u_host.cfg_write(port, CR_UART, 8'h08);
    tick(1);
    chk_bit("tx_pd 1 direct", 1'b1, upm[1].tx_pd);
    chk_bit("rx_pd 1 direct", 1'b1, upm[1].rx_pd);
    chk_bit("tx_pd 0 running", 1'b0, upm[0].tx_pd);
    u_host.cfg_write(port, CR_UART, 8'h80);
    tick(1);
    chk_bit("rx_pd 0 direct", 1'b1, upm[0].rx_pd);
    // disk selects at the default base, then relocated
    for (int i = 0; i < 5; i++)
    begin
      u_host.access(dsk_a[i], 8'h00, 1'b0);
      chk_byte("disk select", {5'h0, dsk_e[i]}, {5'h00, disk});
    end
    u_host.cfg_write(port, CR_PRI, 8'h7C);
    u_host.access(10'h1F0, 8'h12, 1'b1);
    chk_byte("disk select moved", 8'h03, {5'h00, disk});
    // exit, then window ignored and unlock abandoned
    u_host.leave(port);
    u_host.access(port + DATA_OFS, 8'h00, 1'b0);
    chk_bit("rvalid after exit", 1'b0, rvalid);
    u_host.access(port + DATA_OFS, 8'hFF, 1'b1);
    u_host.access(port, UNLOCK_KEY, 1'b1);
    u_host.access(port + 10'h002, UNLOCK_KEY, 1'b1);
    u_host.access(port, UNLOCK_KEY, 1'b1);
    u_host.access(port + DATA_OFS, 8'h00, 1'b0);
    chk_bit("rvalid after abort", 1'b0, rvalid);
    u_host.access(port, UNLOCK_KEY, 1'b1);
    cfg_rd(CR_PRI, 8'h7C);
    // strap high moves the port
    do_reset(1'b1);
    u_host.unlock(CFG_PORT_LO);
    u_host.access(CFG_PORT_LO + DATA_OFS, 8'h00, 1'b0);
    chk_bit("rvalid old port", 1'b0, rvalid);
    u_host.unlock(port);
    cfg_rd(CR_PRI, 8'h3C);
    chk_bit("fdc_pd awake", 1'b0, fdc_pd);
    chk_byte("fdd oe awake", 8'h0F, {4'h0, fdd_o.motor_on_oe, fdd_o.drive_select_oe,
             fdd_o.write_data_oe, fdd_o.write_gate_oe});
    chk_byte("fdd drive pins", fdd[15:8], fdd_o.pins[15:8]);
    wrap_up();
  end
endmodule : test_config_access_and_power_gating
